/* File: logic/ccf_flags.sv */
// status flags of capture/compare channel one
`timescale 1ns/10ps
`include "ccf_map.svh"
// Functional notes
// - output mode: match sets event flag
// - input mode: capture sets event flag
// - write zero or value read clears flag
// - capture while flag set sets overcapture
// - overcapture set in input only; write-zero clears
module ccf_flags #(
	parameter int CNT_W = `CCF_CNT_W	// counter width
) (
	input  wire logic                clk,	// timer clock
	input  wire logic                resetn,	// async reset, low
	input  ccf_pkg::ccf_mode_t       chan_mode,	// channel direction
	input  wire logic [CNT_W-1:0]    counter_value,	// live counter
	input  wire logic [CNT_W-1:0]    cmp_value,	// compare value
	input  wire logic                capture_strobe,	// capture pulse
	input  wire logic                status_wr,	// status write
	input  wire logic [`CCF_STATUS_W-1:0] status_wdata,	// write data
	input  wire logic                value_rd,	// read of cc value
	output logic [CNT_W-1:0]         chan_one_compare_capture_value,	// cc
	output logic                     chan_one_event_flag,	// event flag
	output logic                     chan_one_overcapture_flag	// overcap
);
	import ccf_pkg::*;

	logic mode_in;	// channel in input mode
	logic match_pulse;	// compare match event
	logic capture_pulse;	// capture event
	logic clr_event;	// event flag clear request
	logic clr_overcap;	// overcapture clear request

	// any code other than input counts as output mode
	assign mode_in = (chan_mode == CCF_MODE_IN);

	// match and capture events; the match is an edge of equality
	// so a stalled counter cannot re-set a cleared flag
	ccf_event_det #(.CNT_W(CNT_W)) u_det (
		.clk            (clk),
		.resetn         (resetn),
		.mode_in        (mode_in),
		.counter_value  (counter_value),
		.cmp_value      (cmp_value),
		.capture_strobe (capture_strobe),
		.match_pulse    (match_pulse),
		.capture_pulse  (capture_pulse)
	);

	// a written zero clears, and a value read clears the event flag; a one is ignored
	assign clr_event = (status_wr && !status_wdata[`CCF_EVENT_BIT])
		|| value_rd;
	assign clr_overcap = status_wr
		&& !status_wdata[`CCF_OVERCAP_BIT];

	// captured value; in output mode it follows the compare value
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			chan_one_compare_capture_value <= '0;
		end else if (capture_pulse) begin
			chan_one_compare_capture_value <= counter_value;
		end else if (!mode_in) begin
			chan_one_compare_capture_value <= cmp_value;
		end
	end

	// event flag; a set in the clearing cycle wins
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			chan_one_event_flag <= `CCF_FLAG_RESET;
		end else if (match_pulse || capture_pulse) begin
			chan_one_event_flag <= 1'b1;
		end else if (clr_event) begin
			chan_one_event_flag <= 1'b0;
		end
	end

	// overcapture flag; reading the value does not touch it
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			chan_one_overcapture_flag <= `CCF_FLAG_RESET;
		end else if (capture_pulse && chan_one_event_flag) begin
			chan_one_overcapture_flag <= 1'b1;
		end else if (clr_overcap) begin
			chan_one_overcapture_flag <= 1'b0;
		end
	end

	// a match in output mode raises the event flag next cycle
	match_sets_a: assert property (
		@(posedge clk) disable iff (!resetn)
		(!mode_in && counter_value == cmp_value && !$past(match_pulse)
		 && !$past(!mode_in && counter_value == cmp_value))
		|=> chan_one_event_flag)
		else $error("compare match did not set event flag");

	// a capture in input mode raises the event flag next cycle
	capture_sets_a: assert property (
		@(posedge clk) disable iff (!resetn)
		(mode_in && capture_strobe) |=> chan_one_event_flag)
		else $error("capture did not set event flag");

	// a value read with no event in the same cycle clears the flag
	read_clears_a: assert property (
		@(posedge clk) disable iff (!resetn)
		(value_rd && !match_pulse && !capture_pulse)
		|=> !chan_one_event_flag)
		else $error("value read did not clear event flag");

	// a capture on a still-set event flag raises overcapture
	overcap_sets_a: assert property (
		@(posedge clk) disable iff (!resetn)
		(mode_in && capture_strobe && chan_one_event_flag)
		|=> chan_one_overcapture_flag)
		else $error("repeat capture did not set overcapture");

	// overcapture can only rise while the channel is an input
	overcap_input_a: assert property (
		@(posedge clk) disable iff (!resetn)
		($rose(chan_one_overcapture_flag)) |-> $past(mode_in))
		else $error("overcapture set outside input mode");

	// only a written zero may drop overcapture
	overcap_clear_a: assert property (
		@(posedge clk) disable iff (!resetn)
		($fell(chan_one_overcapture_flag))
		|-> $past(status_wr)
		 && !$past(status_wdata[`CCF_OVERCAP_BIT]))
		else $error("overcapture cleared without write of zero");

	// a written one leaves the event flag set
	write_one_a: assert property (
		@(posedge clk) disable iff (!resetn)
		(chan_one_event_flag && status_wr
		 && status_wdata[`CCF_EVENT_BIT]
		 && !value_rd) |=> chan_one_event_flag)
		else $error("write of one cleared event flag");

	// the event flag falls only through a read or a written zero
	flag_holds_a: assert property (
		@(posedge clk) disable iff (!resetn)
		($fell(chan_one_event_flag))
		|-> $past(value_rd) || ($past(status_wr)
		 && !$past(status_wdata[`CCF_EVENT_BIT])))
		else $error("event flag fell without clearing action");

	// a capture stores the counter value seen in the capture cycle
	capture_value_a: assert property (
		@(posedge clk) disable iff (!resetn)
		capture_pulse
		|=> chan_one_compare_capture_value == $past(counter_value))
		else $error("capture did not store counter value");

	// in input mode the stored value only moves on a capture
	value_holds_a: assert property (
		@(posedge clk) disable iff (!resetn)
		(mode_in && !capture_pulse)
		|=> $stable(chan_one_compare_capture_value))
		else $error("stored value moved without a capture");

	// a hardware set beats a same-cycle clear of the event flag
	event_set_wins_a: assert property (
		@(posedge clk) disable iff (!resetn)
		((match_pulse || capture_pulse) && clr_event)
		|=> chan_one_event_flag)
		else $error("clear beat a same-cycle event set");

	// the event flag rises only on a match or a capture
	event_cause_a: assert property (
		@(posedge clk) disable iff (!resetn)
		$rose(chan_one_event_flag)
		|-> $past(match_pulse) || $past(capture_pulse))
		else $error("event flag rose without an event");

	// without a clear, a set event flag stays set
	event_holds_a: assert property (
		@(posedge clk) disable iff (!resetn)
		(chan_one_event_flag && !clr_event) |=> chan_one_event_flag)
		else $error("event flag dropped without a clear");

	// overcapture needs a capture landing on a still-set event flag
	overcap_cause_a: assert property (
		@(posedge clk) disable iff (!resetn)
		$rose(chan_one_overcapture_flag)
		|-> $past(capture_pulse) && $past(chan_one_event_flag))
		else $error("overcapture rose without a repeat capture");

	// a first capture on a clear event flag is no overcapture
	first_capture_a: assert property (
		@(posedge clk) disable iff (!resetn)
		(capture_pulse && !chan_one_event_flag
		 && !chan_one_overcapture_flag)
		|=> !chan_one_overcapture_flag)
		else $error("first capture set overcapture");

	// output mode never raises the overcapture flag
	overcap_out_a: assert property (
		@(posedge clk) disable iff (!resetn)
		(!mode_in && !chan_one_overcapture_flag)
		|=> !chan_one_overcapture_flag)
		else $error("overcapture set in output mode");

	// reading the value must leave overcapture alone
	overcap_read_a: assert property (
		@(posedge clk) disable iff (!resetn)
		(chan_one_overcapture_flag && value_rd && !clr_overcap)
		|=> chan_one_overcapture_flag)
		else $error("value read cleared overcapture");

	// a written one leaves overcapture set
	overcap_w1_a: assert property (
		@(posedge clk) disable iff (!resetn)
		(chan_one_overcapture_flag && status_wr
		 && status_wdata[`CCF_OVERCAP_BIT])
		|=> chan_one_overcapture_flag)
		else $error("write of one cleared overcapture");

	// a capture beats a same-cycle write of zero to overcapture
	overcap_set_wins_a: assert property (
		@(posedge clk) disable iff (!resetn)
		(capture_pulse && chan_one_event_flag && clr_overcap)
		|=> chan_one_overcapture_flag)
		else $error("clear beat a same-cycle overcapture set");

	// in output mode the value register mirrors the compare value
	value_mirror_a: assert property (
		@(posedge clk) disable iff (!resetn)
		!mode_in
		|=> chan_one_compare_capture_value == $past(cmp_value))
		else $error("value did not follow compare value");

	// a level of equality that stands on gives a single match pulse
	match_once_a: assert property (
		@(posedge clk) disable iff (!resetn)
		match_pulse |=> !match_pulse)
		else $error("standing equality gave a second match");
endmodule : ccf_flags

/* File: logic/ccf_map.svh */
// constants for the channel one status flag block
`ifndef CCF_MAP_SVH
`define CCF_MAP_SVH
`define CCF_EVENT_BIT      1
`define CCF_OVERCAP_BIT    9
`define CCF_STATUS_W       10
`define CCF_CNT_W          16
`define CCF_FLAG_RESET     1'b0
`endif

/* File: logic/ccf_pkg.sv */
// types for the channel one status flag block
package ccf_pkg;
	typedef enum logic [1:0] {
		CCF_MODE_OUT = 2'b01,	// channel drives compare output
		CCF_MODE_IN  = 2'b10	// channel captures input
	} ccf_mode_t;
endpackage : ccf_pkg

/* File: logic/ccf_event_det.sv */
// compare match and capture event detection for channel one
`timescale 1ns/10ps
`include "ccf_map.svh"
module ccf_event_det #(
	parameter int CNT_W = `CCF_CNT_W	// counter width
) (
	input  wire logic             clk,	// timer clock
	input  wire logic             resetn,	// async reset, low
	input  wire logic             mode_in,	// channel in input mode
	input  wire logic [CNT_W-1:0] counter_value,	// live counter
	input  wire logic [CNT_W-1:0] cmp_value,	// compare value
	input  wire logic             capture_strobe,	// capture pulse
	output logic                  match_pulse,	// compare match
	output logic                  capture_pulse	// capture event
);
	logic match_now;	// combinational equality
	logic match_seen;	// equality held last cycle

	// equality is a level; only its rising edge is an event, so a
	// stalled counter does not re-set a flag software just cleared
	assign match_now = !mode_in && (counter_value == cmp_value);

	// remember the previous equality level
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			match_seen <= 1'b0;
		end else begin
			match_seen <= match_now;
		end
	end

	assign match_pulse   = match_now && !match_seen;
	assign capture_pulse = mode_in && capture_strobe;
endmodule : ccf_event_det

/* File: sim/capture_compare_ch1_flags_bench.sv */
// self-checking bench for the channel one status flags
`timescale 1ns/10ps
module capture_compare_ch1_flags_bench;
	import ccf_pkg::*;
	logic        clk = 0;	// timer clock
	logic        resetn = 0;	// async reset, low
	ccf_mode_t   chan_mode = CCF_MODE_IN;	// channel direction
	logic [15:0] counter_value = 0;	// live counter
	logic [15:0] cmp_value = 0;	// compare value
	logic        capture_strobe = 0;	// capture pulse
	logic        status_wr = 0;	// status write
	logic [9:0]  status_wdata = 0;	// write data
	logic        value_rd = 0;	// value read
	logic [15:0] ccv;	// captured value
	logic        evf, ovf;	// flags seen
	int          n_mismatch = 0, checks = 0, cycles = 0;	// tallies
	ccf_flags #(.CNT_W(16)) i_dut (.clk(clk), .resetn(resetn),
		.chan_mode(chan_mode), .counter_value(counter_value),
		.cmp_value(cmp_value), .capture_strobe(capture_strobe),
		.status_wr(status_wr), .status_wdata(status_wdata),
		.value_rd(value_rd), .chan_one_compare_capture_value(ccv),
		.chan_one_event_flag(evf), .chan_one_overcapture_flag(ovf));
	// 200 MHz clock
	initial forever #2.5 clk = ~clk;
	// hang guard, the tests need well under 100 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 1000) begin
			n_mismatch++;
			end_sim();
		end
	end
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : end_sim
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// inputs move just after the edge, so the next edge samples them
	task automatic cyc;
		@(posedge clk);
		#1;
	endtask : cyc
	// one-cycle strobes, dropped after the sampling edge, then an
	// idle edge so a following call never re-raises them at once
	task automatic ev(input logic cap, wr, rd, input logic [9:0] wd);
		capture_strobe = cap;
		status_wr = wr;
		value_rd = rd;
		status_wdata = wd;
		cyc();
		{capture_strobe, status_wr, value_rd} = 3'h0;
		cyc();
	endtask : ev
	// capture, overcapture, read clear and write clear
	task automatic t_cap;
		counter_value = 16'h0005;
		ev(1, 0, 0, 10'h000);
		chk("event", evf, 1);
		chk("value", ccv, 16'h0005);
		counter_value = 16'h0009;
		ev(1, 0, 0, 10'h000);
		chk("overcap", ovf, 1);
		ev(0, 1, 0, 10'h3ff);
		chk("event w1", {evf, ovf}, 2'h3);
		ev(0, 0, 1, 10'h000);
		chk("event rd", {evf, ovf}, 2'h1);
		ev(0, 1, 0, 10'h000);
		chk("overcap w0", ovf, 0);
		ev(1, 0, 0, 10'h000);
		ev(0, 1, 0, 10'h200);
		chk("event w0", {evf, ovf}, 2'h0);
		ev(1, 0, 1, 10'h000);
		chk("set wins rd", {evf, ovf}, 2'h2);
		ev(1, 1, 0, 10'h000);
		chk("set wins w0", {evf, ovf}, 2'h3);
		ev(0, 1, 0, 10'h000);
		chk("both w0", {evf, ovf}, 2'h0);
		$display("capture test done");
	endtask : t_cap
	// compare match in output mode, no overcapture there
	task automatic t_cmp;
		chan_mode = CCF_MODE_OUT;
		cmp_value = 16'h0020;
		counter_value = 16'h001f;
		cyc();
		cyc();
		chk("no match", evf, 0);
		counter_value = 16'h0020;
		cyc();
		cyc();
		chk("match", evf, 1);
		chk("out value", ccv, 16'h0020);
		ev(0, 1, 0, 10'h000);
		chk("match once", evf, 0);
		counter_value = 16'h0021;
		cyc();
		counter_value = 16'h0020;
		cyc();
		cyc();
		chk("rematch", evf, 1);
		ev(0, 0, 1, 10'h000);
		chk("out read", evf, 0);
		ev(1, 0, 0, 10'h000);
		chk("out overcap", ovf, 0);
		$display("compare test done");
	endtask : t_cmp
	initial begin
		repeat (4) @(posedge clk);
		#1 resetn = 1;
		chk("reset", {evf, ovf}, 2'h0);
		t_cap();
		t_cmp();
		end_sim();
	end
endmodule : capture_compare_ch1_flags_bench
